// File: rtl/bod_core.sv
// Notes on behaviour
// - inc_skip_nonzero_op: f+1 stored, skip on non-zero, flags kept.
// - destination bit 0 writes the working register, 1 the file register.
// - access bit 0 picks the access bank, 1 uses bank_select_reg.
// - extended set on, access bit 0 and f <= 95: indexed literal offset.
// - a skip increment takes 1 cycle, 2 on a skip, 3 over a 2-word one.
// - a skipped word becomes an idle cycle, a skipped 2-word one two.
// - or_literal_op ORs the literal into W in one cycle, N and Z only.
// - or_register_op ORs W with f, routed by the destination bit, N and Z.
// - pointer_load_op: 12-bit literal to pointer 0..2, high then low.
// - move_byte_op copies f to the chosen destination, N and Z.
// - mem_to_mem_move_op: 12-bit source then destination, flags kept.
// - mem_to_mem_move_op may use W either way and takes two cycles.
// - inc_skip_zero_op: f+1 stored, skip on a zero result, flags kept.
`timescale 1ns/100ps
`default_nettype none
module bod_core import bod_pkg::*; #(
  parameter int DATA_DEPTH = 4096
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // instruction stream
  input wire logic [15:0] instr_word_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  // avalon-mm slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  // ==========================================================
  // state
  bod_phase_type q_phase;
  bod_cycle_type cyc_state;
  bod_cycle_type next_cyc;
  logic [15:0] ir_word;
  logic [7:0] data_mem [DATA_DEPTH];
  logic [7:0] work;
  logic [3:0] bank_select_reg;
  logic [11:0] indirect_pointer_reg [3];
  logic ext_en;
  logic n_flag;
  logic z_flag;
  logic [7:0] operand;
  logic [7:0] result;
  logic skip_take;
  logic second_is_ptr;
  logic [1:0] ptr_sel;
  logic [11:0] mem_addr;
  logic take;
  logic bus_req;
  logic bus_do;
  bod_decoded_type dec;
  logic [11:0] file_addr;
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic flags_en;
  assign take = ce_i && q_phase == Q1 && instr_ready_o && instr_valid_i;
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_do = ce_i && bus_req && !avs_waitrequest_o;
  // ==========================================================
  // decode
  function automatic bod_op_type decode_op(input logic [15:0] w);
    bod_op_type o;
    o = OP_NONE;
    if (w[15:10] == OPC_INC_SKIP_NONZERO) o = OP_INC_NZ;
    else if (w[15:10] == OPC_INC_SKIP_ZERO) o = OP_INC_Z;
    else if (w[15:10] == OPC_OR_REGISTER) o = OP_OR_REG;
    else if (w[15:10] == OPC_MOVE_BYTE) o = OP_MOVE;
    else if (w[15:8] == OPC_OR_LITERAL) o = OP_OR_LIT;
    else if (w[15:8] == OPC_POINTER_LOAD) o = OP_PTR_LOAD;
    else if (w[15:12] == OPC_MEM_TO_MEM) o = OP_M2M;
    return o;
  endfunction
  function automatic logic two_word(input logic [15:0] w);
    return w[15:12] == OPC_MEM_TO_MEM || w[15:8] == OPC_POINTER_LOAD ||
           w[15:9] == OPC_CALL || w[15:8] == OPC_GOTO;
  endfunction
  always_comb begin
    dec.op = (cyc_state == CY_EXEC) ? decode_op(ir_word) : OP_NONE;
    dec.dest_file = ir_word[9];
    dec.banked = ir_word[8];
    dec.f = ir_word[7:0];
  end

  // ==========================================================
  // file address formation
  always_comb begin
    if (dec.banked) begin
      file_addr = {bank_select_reg, dec.f};
    end else if (ext_en && dec.f <= IDX_LIMIT) begin
      file_addr = indirect_pointer_reg[IDX_PTR] + {4'h0, dec.f};
    end else if (dec.f[7]) begin
      file_addr = {SFR_BANK, dec.f};
    end else begin
      file_addr = {LOW_BANK, dec.f};
    end
  end
  // source is the first word's 12-bit field for the move, else f
  assign rd_addr = (dec.op == OP_M2M) ? ir_word[11:0] : file_addr;
  // ==========================================================
  // phase and cycle sequencing
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_phase <= Q1;
    end else if (ce_i) begin
      case (q_phase)
        Q1: if (take) q_phase <= Q2;
        Q2: q_phase <= Q3;
        Q3: q_phase <= Q4;
        Q4: q_phase <= Q1;
        default: q_phase <= Q1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      instr_ready_o <= 1'b1;
    end else if (ce_i) begin
      if (take) instr_ready_o <= 1'b0;
      else if (q_phase == Q4) instr_ready_o <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_word <= 16'h0000;
    end else if (take) begin
      ir_word <= instr_word_i;
    end
  end
  always_comb begin
    case (cyc_state)
      CY_EXEC: begin
        if (dec.op == OP_M2M || dec.op == OP_PTR_LOAD) next_cyc = CY_SECOND;
        else if (skip_take) next_cyc = CY_SKIP;
        else next_cyc = CY_EXEC;
      end
      CY_SECOND: next_cyc = CY_EXEC;
      CY_SKIP: next_cyc = two_word(ir_word) ? CY_SKIP2 : CY_EXEC;
      CY_SKIP2: next_cyc = CY_EXEC;
      default: next_cyc = CY_EXEC;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_state <= CY_EXEC;
    end else if (ce_i && q_phase == Q4) begin
      cyc_state <= next_cyc;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      second_is_ptr <= 1'b0;
      ptr_sel <= 2'b00;
    end else if (ce_i && q_phase == Q4 && cyc_state == CY_EXEC) begin
      second_is_ptr <= dec.op == OP_PTR_LOAD;
      ptr_sel <= ir_word[5:4];
    end
  end

  // ==========================================================
  // read in q2, process in q3
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      operand <= RST_BYTE;
    end else if (ce_i && q_phase == Q2 && cyc_state == CY_EXEC) begin
      operand <= (rd_addr == W_ADDR) ? work : data_mem[rd_addr];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result <= RST_BYTE;
      skip_take <= 1'b0;
    end else if (ce_i && q_phase == Q3) begin
      skip_take <= 1'b0;
      case (dec.op)
        OP_INC_NZ: begin
          result <= operand + 8'h01;
          skip_take <= (operand + 8'h01) != 8'h00;
        end
        OP_INC_Z: begin
          result <= operand + 8'h01;
          skip_take <= (operand + 8'h01) == 8'h00;
        end
        OP_OR_LIT: result <= work | dec.f;
        OP_OR_REG: result <= work | operand;
        OP_MOVE: result <= operand;
        default: result <= operand;
      endcase
    end
  end

  // ==========================================================
  // write in q4
  always_comb begin
    wr_en = 1'b0;
    wr_addr = file_addr;
    wr_data = result;
    flags_en = 1'b0;
    case (dec.op)
      OP_INC_NZ, OP_INC_Z: wr_en = 1'b1;
      OP_OR_REG, OP_MOVE: begin
        wr_en = 1'b1;
        flags_en = 1'b1;
      end
      OP_OR_LIT: begin
        wr_en = 1'b1;
        wr_addr = W_ADDR;
        flags_en = 1'b1;
      end
      default: wr_en = 1'b0;
    endcase
    if (wr_en && !dec.dest_file && dec.op != OP_OR_LIT) begin
      wr_addr = W_ADDR;
    end
    if (cyc_state == CY_SECOND && !second_is_ptr) begin
      wr_en = 1'b1;
      wr_addr = ir_word[11:0];
      wr_data = operand;
    end
    wr_en = wr_en && ce_i && q_phase == Q4;
  end

  always_ff @(posedge core_clk_i) begin
    if (wr_en && wr_addr != W_ADDR) begin
      data_mem[wr_addr] <= wr_data;
    end else if (bus_do && avs_write_i && avs_byteenable_i[0] &&
                 avs_address_i == REG_MEM_DATA) begin
      data_mem[mem_addr] <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      work <= RST_BYTE;
    end else if (wr_en && wr_addr == W_ADDR) begin
      work <= wr_data;
    end else if (bus_do && avs_write_i && avs_byteenable_i[0] &&
                 avs_address_i == REG_WORK) begin
      work <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_flag <= 1'b0;
      z_flag <= 1'b0;
    end else if (wr_en && flags_en) begin
      n_flag <= wr_data[7];
      z_flag <= wr_data == 8'h00;
    end
  end

  // ==========================================================
  // pointer registers
  for (genvar gi = 0; gi < PTR_COUNT; gi++) begin : g_ptr
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        indirect_pointer_reg[gi] <= RST_PTR;
      end else if (ce_i && q_phase == Q4) begin
        if (dec.op == OP_PTR_LOAD && ir_word[5:4] == 2'(gi)) begin
          indirect_pointer_reg[gi][11:8] <= ir_word[3:0];
        end else if (cyc_state == CY_SECOND && second_is_ptr &&
                     ptr_sel == 2'(gi)) begin
          indirect_pointer_reg[gi][7:0] <= ir_word[7:0];
        end
      end
    end
  end

  // ==========================================================
  // avalon-mm slave
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_en <= 1'b0;
      bank_select_reg <= 4'h0;
      mem_addr <= RST_PTR;
    end else if (bus_do && avs_write_i) begin
      if (avs_byteenable_i[0]) begin
        case (avs_address_i)
          REG_CTRL: ext_en <= avs_writedata_i[0];
          REG_BANK: bank_select_reg <= avs_writedata_i[3:0];
          default: ext_en <= ext_en;
        endcase
      end
      if (avs_address_i == REG_MEM_ADDR) begin
        if (avs_byteenable_i[0]) mem_addr[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) mem_addr[11:8] <= avs_writedata_i[11:8];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= RST_WORD;
    end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= RST_WORD;
      case (avs_address_i)
        REG_CTRL: avs_readdata_o[0] <= ext_en;
        REG_BANK: avs_readdata_o[3:0] <= bank_select_reg;
        REG_WORK: avs_readdata_o[7:0] <= work;
        REG_STATUS: begin
          avs_readdata_o[STATUS_Z_BIT] <= z_flag;
          avs_readdata_o[STATUS_N_BIT] <= n_flag;
          avs_readdata_o[STATUS_BUSY_BIT] <= cyc_state != CY_EXEC;
        end
        REG_PTR0: avs_readdata_o[11:0] <= indirect_pointer_reg[0];
        REG_PTR1: avs_readdata_o[11:0] <= indirect_pointer_reg[1];
        REG_PTR2: avs_readdata_o[11:0] <= indirect_pointer_reg[2];
        REG_MEM_ADDR: avs_readdata_o[11:0] <= mem_addr;
        REG_MEM_DATA: avs_readdata_o[7:0] <= data_mem[mem_addr];
        default: avs_readdata_o <= RST_WORD;
      endcase
    end
  end
endmodule // bod_core
`default_nettype wire

// File: rtl/bod_pkg.sv
// ============================================================
// shared constants and types
package bod_pkg;
  // ==========================================================
  // opcode patterns, taken from the top bits of a word
  localparam logic [5:0] OPC_INC_SKIP_NONZERO = 6'h12;
  localparam logic [5:0] OPC_INC_SKIP_ZERO = 6'h0F;
  localparam logic [5:0] OPC_OR_REGISTER = 6'h04;
  localparam logic [5:0] OPC_MOVE_BYTE = 6'h14;
  localparam logic [7:0] OPC_OR_LITERAL = 8'h09;
  localparam logic [7:0] OPC_POINTER_LOAD = 8'hEE;
  localparam logic [3:0] OPC_MEM_TO_MEM = 4'hC;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [7:0] OPC_GOTO = 8'hEF;
  // ==========================================================
  // addressing
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [3:0] SFR_BANK = 4'hF;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [11:0] W_ADDR = 12'hFE8;
  localparam logic [1:0] IDX_PTR = 2'h2;
  localparam logic [1:0] PTR_COUNT = 2'h3;
  // ==========================================================
  // register map, byte addresses
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_BANK = 6'h04;
  localparam logic [5:0] REG_WORK = 6'h08;
  localparam logic [5:0] REG_STATUS = 6'h0C;
  localparam logic [5:0] REG_PTR0 = 6'h10;
  localparam logic [5:0] REG_PTR1 = 6'h14;
  localparam logic [5:0] REG_PTR2 = 6'h18;
  localparam logic [5:0] REG_MEM_ADDR = 6'h1C;
  localparam logic [5:0] REG_MEM_DATA = 6'h20;
  localparam int STATUS_Z_BIT = 0;
  localparam int STATUS_N_BIT = 1;
  localparam int STATUS_BUSY_BIT = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    Q1 = 4'b0001, Q2 = 4'b0010, Q3 = 4'b0100, Q4 = 4'b1000
  } bod_phase_type;
  typedef enum logic [3:0] {
    CY_EXEC = 4'b0001, CY_SECOND = 4'b0010,
    CY_SKIP = 4'b0100, CY_SKIP2 = 4'b1000
  } bod_cycle_type;
  typedef enum logic [2:0] {
    OP_NONE, OP_INC_NZ, OP_INC_Z, OP_OR_LIT, OP_OR_REG,
    OP_MOVE, OP_PTR_LOAD, OP_M2M
  } bod_op_type;
  typedef struct packed {
    bod_op_type op;
    logic dest_file;
    logic banked;
    logic [7:0] f;
  } bod_decoded_type;
endpackage

// File: test/bod_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker
module bod_core_properties import bod_pkg::*; #(
  parameter int DATA_DEPTH = 4096
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // instruction stream
  input wire logic [15:0] instr_word_i,
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  // avalon-mm
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  wire logic take = ce_i && instr_valid_i && instr_ready_o;
  wire logic req_wait = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  wire logic unmapped = avs_address_i > 6'h20 || avs_address_i[1:0] != 2'h0;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_take_idle;
    take |=> !instr_ready_o [*3];
  endproperty
  a_take_idle: assert property (p_take_idle)
    else $error("ready back too soon after take");
  property p_take_back;
    take ##1 ce_i [*3] |=> instr_ready_o;
  endproperty
  a_take_back: assert property (p_take_back)
    else $error("ready not back after three enabled cycles");
  property p_ce_freeze;
    !ce_i |=> $stable(instr_ready_o) && $stable(avs_waitrequest_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("outputs moved while clock enable low");
  property p_ready_cause;
    $rose(instr_ready_o) |-> $past(ce_i) && ($past(take, 4) ||
      !$past(ce_i, 2) || !$past(ce_i, 3) || !$past(ce_i, 4));
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready rose without a take four cycles before");
  property p_ready_stand;
    instr_ready_o && !take |=> instr_ready_o;
  endproperty
  a_ready_stand: assert property (p_ready_stand)
    else $error("ready dropped without a take");
  property p_wait_ans;
    req_wait |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("waitrequest not low one cycle after request");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_wait_cause;
    !avs_waitrequest_o |-> $past(req_wait);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("waitrequest low without a request");
  property p_rd_hold;
    !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && unmapped |-> avs_readdata_o == 0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // bod_core_properties

bind bod_core bod_core_properties #(.DATA_DEPTH(DATA_DEPTH)) i_props (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .instr_word_i(instr_word_i), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o)
);
`default_nettype wire

// File: test/bod_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bod_core_tb import bod_pkg::*;;
  logic core_clk_i = 0, rst_b_i = 0, ce_i = 1, instr_valid_i = 0;
  logic avs_read_i = 0, avs_write_i = 0, instr_ready_o, avs_waitrequest_o;
  logic [15:0] instr_word_i = 16'h0000;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] seed = 32'h7215_3ad1;
  logic mn = 0, mz = 0;
  int error_cnt = 0, n_tests = 0, cyc = 0, mbank = 0, mext = 0;
  int mm [4096];
  int mptr [3];
  // lowest byte a move must not target; value is an arbitrary bench choice
  localparam int CTRL_AREA = 'hFF8;
  bod_core i_dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .instr_word_i(instr_word_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o)
  );
  // ==========================================
  // clock, timeout and helpers
  initial forever #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      give_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ea(logic [7:0] f, logic a);
    if (a) return {mbank[3:0], f};
    if (mext[0] && f <= IDX_LIMIT) return (mptr[2] + f) & 'hFFF;
    return f < 8'h80 ? int'(f) : 'hF00 | f;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    do @(posedge core_clk_i); while (instr_ready_o !== 1'b1);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  task acc(input logic wr, input int ad, input logic [7:0] v);
    if (ad != 'hFE8) bus(1, REG_MEM_ADDR, 32'(ad));
    bus(wr, ad == 'hFE8 ? REG_WORK : REG_MEM_DATA, {24'h0, v});
    if (wr) mm[ad] = v;
  endtask
  task send(input logic [15:0] w);
    @(posedge core_clk_i);
    instr_word_i <= w;
    instr_valid_i <= 1;
    do @(posedge core_clk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 0;
  endtask
  // ==========================================
  // one random instruction, with a follower after the two skip increments only
  task automatic step();
    logic [31:0] r, k;
    logic [7:0] f, v, res;
    logic [5:0] opc;
    logic skip;
    int op, ad, idx;
    r = rnd();
    k = rnd();
    f = r[7:0];
    op = r[12:10] % 7;
    mbank = r[16:13];
    mext = r[17];
    idx = r[20:19] % 3;
    bus(1, REG_BANK, mbank);
    bus(1, REG_CTRL, mext);
    acc(1, 'hFE8, k[23:16]);
    ad = op == 6 ? int'(k[11:0]) : ea(f, r[9]);
    acc(1, ad, r[18] ? 8'hFF : r[31:24]);
    v = mm[ad];
    case (op)
      0, 1, 2, 3: begin
        opc = op == 0 ? OPC_INC_SKIP_NONZERO : op == 1 ? OPC_INC_SKIP_ZERO :
          op == 2 ? OPC_OR_REGISTER : OPC_MOVE_BYTE;
        res = op < 2 ? v + 8'h01 : op == 2 ? v | mm['hFE8][7:0] : v;
        send({opc, r[8], r[9], f});
        ce_i <= 0;
        repeat (1 + r[23:21]) @(posedge core_clk_i);
        ce_i <= 1;
        mm[r[8] ? ad : 'hFE8] = res;
        if (op > 1) {mn, mz} = {res[7], res == 8'h00};
        skip = op == 0 ? res != 8'h00 : res == 8'h00;
        if (op < 2) begin
          bus(0, REG_STATUS, 0);
          chk(q[2], skip);
          if (k[31]) send({OPC_POINTER_LOAD, 2'b00, 2'(idx), k[27:24]});
          else send({OPC_OR_LITERAL, k[31:24]});
          if (k[31]) send({8'hF0, k[7:0]});
          if (!skip && k[31]) mptr[idx] = {k[27:24], k[7:0]};
          if (!skip && !k[31]) mm['hFE8] |= k[31:24];
          if (!skip && !k[31]) {mn, mz} = {mm['hFE8][7], mm['hFE8] == 0};
        end
      end
      4: begin
        send({OPC_OR_LITERAL, r[31:24]});
        mm['hFE8] |= r[31:24];
        {mn, mz} = {mm['hFE8][7], mm['hFE8] == 0};
      end
      5: begin
        send({OPC_POINTER_LOAD, 2'b00, 2'(idx), k[11:8]});
        bus(0, REG_STATUS, 0);
        chk(q[2], 1'b1);
        send({8'hF0, k[7:0]});
        mptr[idx] = k[11:0];
      end
      default: begin
        ad = rnd() & 'hFFF;
        if (ad >= CTRL_AREA) ad = ad - 'h10;
        send({OPC_MEM_TO_MEM, k[11:0]});
        send({4'hF, 12'(ad)});
        mm[ad] = v;
      end
    endcase
    acc(0, ad, 8'h00);
    chk(q, mm[ad]);
    acc(0, 'hFE8, 8'h00);
    chk(q, mm['hFE8]);
    bus(0, REG_STATUS, 0);
    chk(q[2:0], {1'b0, mn, mz});
    for (int i = 0; i < 3; i++) begin
      bus(0, REG_PTR0 + 6'(4 * i), 0);
      chk(q, mptr[i]);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    mptr = '{0, 0, 0};
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1;
    for (int a = 0; a <= 'h18; a += 4) begin
      bus(0, 6'(a), 0);
      chk(q, 0);
    end
    bus(1, 6'h24, 32'hFFFF_FFFF);
    bus(0, 6'h24, 0);
    chk(q, 0);
    bus(0, 6'h3E, 0);
    chk(q, 0);
    $display("reset and map test done");
    for (int i = 0; i < 250; i++) step();
    $display("random instruction test done");
    give_verdict();
  end
endmodule // bod_core_tb
`default_nettype wire
